// File: design/local_bus_device.sv
// Device end of the local processor bus: register slave and bus master
`timescale 1ns/10ps
`include "local_bus_map.svh"
module local_bus_device
	import local_bus_pkg::*;
#(
	parameter int ADDR_W = `LB_ADDR_W,
	parameter int DATA_W = `LB_DATA_W,
	parameter int DEC_W = `LB_DEC_W,
	parameter int REF_HALF = `LB_REF_HALF
)
(
	input wire logic clock_i,
	input wire logic sys_rst_i,
	local_bus_if.device_end bus,
	input wire logic master_enable_i,
	input wire logic mst_req_i,
	input wire logic mst_write_i,
	input wire logic [ADDR_W-1:0] mst_addr_i,
	input wire logic [DATA_W-1:0] mst_wdata_i,
	output logic mst_done_o,
	output logic [DATA_W-1:0] mst_rdata_o,
	output logic slv_wr_o,
	output logic [DEC_W-1:0] slv_addr_o,
	output logic [DATA_W-1:0] slv_data_o
);
	localparam int REGS = 1 << DEC_W;
	localparam int DIV_W = (REF_HALF > 1) ? $clog2(REF_HALF) : 1;

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic strap_done;
		logic style;
		logic [1:0] cs_s;
		logic [1:0] rd_s;
		logic [1:0] wr_s;
		slave_state_type sst;
		master_state_type mst;
		logic mwrite;
		logic rdy_prev;
		logic [ADDR_W-1:0] addr;
		logic addr_oe_n;
		logic [DATA_W-1:0] data;
		logic data_oe_n;
		logic rd;
		logic wr;
		logic strb_oe_n;
		logic rdy;
		logic rdy_oe_n;
		logic [DIV_W-1:0] div;
		logic ref_clk;
		logic mst_done;
		logic [DATA_W-1:0] mst_rdata;
		logic slv_wr;
		logic [DEC_W-1:0] slv_addr;
		logic [DATA_W-1:0] slv_data;
		logic [REGS-1:0][DATA_W-1:0] regs;
	} state_type;

	state_type r, next_r;
	logic sep, rd_on, wr_on, strobe_on, cs_on, slv_rd, slv_wrq;
	logic rdy_lvl, rdy_act, wr_idle;
	logic [DEC_W-1:0] dec;

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	// Strobe decode reads only the second synchroniser stage; address decode reads the lines direct
	always_comb
	begin
		next_r = r;
		sep = (r.style == `LB_STYLE_SEP);
		cs_on = (r.cs_s[1] == `LB_ACTIVE_N);
		rd_on = (r.rd_s[1] == `LB_ACTIVE_N);
		wr_on = (r.wr_s[1] == `LB_ACTIVE_N);
		strobe_on = sep ? (rd_on || wr_on) : rd_on;
		slv_rd = sep ? rd_on :
			(rd_on && r.wr_s[1] == `LB_DIR_READ);
		slv_wrq = sep ? (wr_on && !rd_on) :
			(rd_on && r.wr_s[1] != `LB_DIR_READ);
		rdy_lvl = sep ? `LB_RDY_SEP : `LB_RDY_DS;
		rdy_act = (bus.cycle_ready == rdy_lvl);
		wr_idle = sep ? `LB_IDLE_N : `LB_DIR_READ;
		dec = bus.local_address_lines[DEC_W-1:0];
		next_r.cs_s = {r.cs_s[0], bus.slave_chip_select_n};
		next_r.rd_s = {r.rd_s[0], bus.read_strobe_n};
		next_r.wr_s = {r.wr_s[0], bus.write_strobe_n};
		next_r.rdy_prev = rdy_act;
		next_r.slv_wr = 1'b0;
		next_r.mst_done = 1'b0;

		// Strap is taken once, the first cycle after reset
		if (!r.strap_done)
		begin
			next_r.style = bus.bus_style_strap;
			next_r.strap_done = 1'b1;
		end

		// Reference clock toggles every REF_HALF cycles
		if (r.div == DIV_W'(REF_HALF - 1))
		begin
			next_r.div = '0;
			next_r.ref_clk = ~r.ref_clk;
		end
		else
			next_r.div = r.div + 1'b1;

		// Address and strobe pins belong to us only in master mode
		next_r.addr_oe_n = master_enable_i ? `LB_OE_ON : `LB_OE_OFF;
		next_r.strb_oe_n = master_enable_i ? `LB_OE_ON : `LB_OE_OFF;

		// Slave side; the hold state makes one access per strobe
		case (r.sst)
			SL_IDLE:
			begin
				next_r.rdy_oe_n = `LB_OE_OFF;
				if (cs_on && !master_enable_i && r.strap_done &&
					(slv_rd || slv_wrq))
				begin
					next_r.rdy = ~rdy_lvl;
					next_r.rdy_oe_n = `LB_OE_ON;
					next_r.sst = SL_READY;
					if (slv_rd)
					begin
						next_r.data = r.regs[dec];
						next_r.data_oe_n = `LB_OE_ON;
					end
					else
					begin
						next_r.regs[dec] = bus.local_data_lines;
						next_r.slv_wr = 1'b1;
						next_r.slv_addr = dec;
						next_r.slv_data = bus.local_data_lines;
					end
				end
			end
			SL_READY:
			begin
				// Data or latch is one cycle old when ready rises
				next_r.rdy = rdy_lvl;
				next_r.sst = SL_HOLD;
			end
			SL_HOLD:
			begin
				if (!cs_on || !strobe_on)
				begin
					next_r.data_oe_n = `LB_OE_OFF;
					next_r.rdy_oe_n = `LB_OE_OFF;
					next_r.sst = SL_IDLE;
				end
			end
			default:
				next_r.sst = SL_IDLE;
		endcase

		// Master side
		case (r.mst)
			M_IDLE:
			begin
				if (master_enable_i)
				begin
					next_r.rd = `LB_IDLE_N;
					next_r.wr = wr_idle;
					if (mst_req_i && r.sst == SL_IDLE && r.strap_done)
					begin
						next_r.addr = mst_addr_i;
						next_r.mwrite = mst_write_i;
						next_r.data = mst_wdata_i;
						next_r.data_oe_n = mst_write_i ? `LB_OE_ON : `LB_OE_OFF;
						if (!sep)
							next_r.wr = mst_write_i ? ~`LB_DIR_READ :
								`LB_DIR_READ;
						next_r.mst = M_SETUP;
					end
				end
			end
			M_SETUP:
			begin
				if (sep)
				begin
					next_r.rd = r.mwrite ? `LB_IDLE_N : `LB_ACTIVE_N;
					next_r.wr = r.mwrite ? `LB_ACTIVE_N : `LB_IDLE_N;
				end
				else
					next_r.rd = `LB_ACTIVE_N;
				next_r.mst = M_STROBE;
			end
			M_STROBE:
			begin
				// Only a fresh ready edge ends the cycle
				if (rdy_act && !r.rdy_prev)
				begin
					if (!r.mwrite)
						next_r.mst_rdata = bus.local_data_lines;
					next_r.mst_done = 1'b1;
					next_r.rd = `LB_IDLE_N;
					next_r.wr = wr_idle;
					next_r.data_oe_n = `LB_OE_OFF;
					next_r.mst = M_IDLE;
				end
			end
			default:
				next_r.mst = M_IDLE;
		endcase

		// Dropping master mode abandons a cycle without a done pulse
		if (!master_enable_i && r.mst != M_IDLE)
		begin
			next_r.mst = M_IDLE;
			next_r.data_oe_n = `LB_OE_OFF;
		end
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	// Synchronous reset to an idle, released bus
	always_ff @(posedge clock_i)
	begin
		if (sys_rst_i)
		begin
			r <= '0;
			r.cs_s <= {2{`LB_IDLE_N}};
			r.rd_s <= {2{`LB_IDLE_N}};
			r.wr_s <= {2{`LB_IDLE_N}};
			r.addr_oe_n <= `LB_OE_OFF;
			r.data_oe_n <= `LB_OE_OFF;
			r.strb_oe_n <= `LB_OE_OFF;
			r.rdy_oe_n <= `LB_OE_OFF;
			r.rd <= `LB_IDLE_N;
			r.wr <= `LB_IDLE_N;
			r.rdy <= `LB_IDLE_N;
		end
		else
			r <= next_r;
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	// All straight from the state register
	assign bus.local_ref_clock_out = r.ref_clk;
	assign bus.dev_addr = r.addr;
	assign bus.dev_addr_oe_n = r.addr_oe_n;
	assign bus.dev_data = r.data;
	assign bus.dev_data_oe_n = r.data_oe_n;
	assign bus.dev_rd = r.rd;
	assign bus.dev_wr = r.wr;
	assign bus.dev_strb_oe_n = r.strb_oe_n;
	assign bus.dev_rdy = r.rdy;
	assign bus.dev_rdy_oe_n = r.rdy_oe_n;
	assign mst_done_o = r.mst_done;
	assign mst_rdata_o = r.mst_rdata;
	assign slv_wr_o = r.slv_wr;
	assign slv_addr_o = r.slv_addr;
	assign slv_data_o = r.slv_data;
endmodule

// File: design/local_bus_host.sv
// Processor end of the local bus: register master and local peripheral
`timescale 1ns/10ps
`include "local_bus_map.svh"
module local_bus_host
	import local_bus_pkg::*;
#(
	parameter int ADDR_W = `LB_ADDR_W,
	parameter int DATA_W = `LB_DATA_W
)
(
	input wire logic clock_i,
	input wire logic sys_rst_i,
	local_bus_if.host_end bus,
	input wire logic strap_i,
	input wire logic periph_mode_i,
	input wire logic cpu_req_i,
	input wire logic cpu_write_i,
	input wire logic [ADDR_W-1:0] cpu_addr_i,
	input wire logic [DATA_W-1:0] cpu_wdata_i,
	output logic cpu_done_o,
	output logic [DATA_W-1:0] cpu_rdata_o,
	input wire logic [DATA_W-1:0] periph_rdata_i,
	output logic periph_wr_o,
	output logic [ADDR_W-1:0] periph_addr_o,
	output logic [DATA_W-1:0] periph_wdata_o
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic strap;
		host_state_type hst;
		logic hwrite;
		logic rdy_prev;
		logic cs_n;
		logic [ADDR_W-1:0] addr;
		logic addr_oe_n;
		logic [DATA_W-1:0] data;
		logic data_oe_n;
		logic rd;
		logic wr;
		logic strb_oe_n;
		logic rdy;
		logic rdy_oe_n;
		logic cpu_done;
		logic [DATA_W-1:0] cpu_rdata;
		logic periph_wr;
		logic [ADDR_W-1:0] periph_addr;
		logic [DATA_W-1:0] periph_wdata;
	} state_type;

	state_type r, next_r;
	logic sep, strobe_on, p_read, rdy_lvl, rdy_act, wr_idle;

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	// Bus pins are synchronous here, so no synchroniser is needed
	always_comb
	begin
		next_r = r;
		sep = (r.strap == `LB_STYLE_SEP);
		strobe_on = sep ? (bus.read_strobe_n == `LB_ACTIVE_N ||
			bus.write_strobe_n == `LB_ACTIVE_N) :
			(bus.data_strobe_n == `LB_ACTIVE_N);
		p_read = sep ? (bus.read_strobe_n == `LB_ACTIVE_N) :
			(bus.direction_line == `LB_DIR_READ);
		rdy_lvl = sep ? `LB_RDY_SEP : `LB_RDY_DS;
		rdy_act = (bus.cycle_ready == rdy_lvl);
		wr_idle = sep ? `LB_IDLE_N : `LB_DIR_READ;
		next_r.strap = strap_i;
		next_r.rdy_prev = rdy_act;
		next_r.cpu_done = 1'b0;
		next_r.periph_wr = 1'b0;
		// Peripheral mode hands address and strobes to the device
		next_r.addr_oe_n = periph_mode_i ? `LB_OE_OFF : `LB_OE_ON;
		next_r.strb_oe_n = periph_mode_i ? `LB_OE_OFF : `LB_OE_ON;

		case (r.hst)
			H_IDLE:
			begin
				next_r.rdy_oe_n = `LB_OE_OFF;
				next_r.rd = `LB_IDLE_N;
				next_r.wr = wr_idle;
				if (periph_mode_i && strobe_on)
				begin
					next_r.rdy = ~rdy_lvl;
					next_r.rdy_oe_n = `LB_OE_ON;
					next_r.hst = P_ACK;
					if (p_read)
					begin
						next_r.data = periph_rdata_i;
						next_r.data_oe_n = `LB_OE_ON;
					end
					else
					begin
						next_r.periph_wr = 1'b1;
						next_r.periph_addr = bus.local_address_lines;
						next_r.periph_wdata = bus.local_data_lines;
					end
				end
				else if (!periph_mode_i && cpu_req_i)
				begin
					next_r.cs_n = `LB_ACTIVE_N;
					next_r.addr = cpu_addr_i;
					next_r.hwrite = cpu_write_i;
					next_r.data = cpu_wdata_i;
					if (!sep)
						next_r.wr = cpu_write_i ? ~`LB_DIR_READ :
							`LB_DIR_READ;
					next_r.hst = H_SETUP;
				end
			end
			H_SETUP:
			begin
				// Write data waits a cycle: device may still hold old read data
				next_r.data_oe_n = r.hwrite ? `LB_OE_ON : `LB_OE_OFF;
				if (sep)
				begin
					next_r.rd = r.hwrite ? `LB_IDLE_N : `LB_ACTIVE_N;
					next_r.wr = r.hwrite ? `LB_ACTIVE_N : `LB_IDLE_N;
				end
				else
					next_r.rd = `LB_ACTIVE_N;
				next_r.hst = H_STROBE;
			end
			H_STROBE:
			begin
				// Wait for a fresh ready edge from the device
				if (rdy_act && !r.rdy_prev)
				begin
					if (!r.hwrite)
						next_r.cpu_rdata = bus.local_data_lines;
					next_r.cpu_done = 1'b1;
					next_r.cs_n = `LB_IDLE_N;
					next_r.rd = `LB_IDLE_N;
					next_r.wr = wr_idle;
					next_r.data_oe_n = `LB_OE_OFF;
					next_r.hst = H_IDLE;
				end
			end
			P_ACK:
			begin
				next_r.rdy = rdy_lvl;
				next_r.hst = P_WAIT;
			end
			P_WAIT:
			begin
				if (!strobe_on)
				begin
					next_r.rdy_oe_n = `LB_OE_OFF;
					next_r.data_oe_n = `LB_OE_OFF;
					next_r.hst = H_IDLE;
				end
			end
			default:
				next_r.hst = H_IDLE;
		endcase
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	// Strap follows its input even in reset so the device sees it early
	always_ff @(posedge clock_i)
	begin
		if (sys_rst_i)
		begin
			r <= '0;
			r.strap <= strap_i;
			r.cs_n <= `LB_IDLE_N;
			r.addr_oe_n <= `LB_OE_OFF;
			r.data_oe_n <= `LB_OE_OFF;
			r.strb_oe_n <= `LB_OE_OFF;
			r.rdy_oe_n <= `LB_OE_OFF;
			r.rd <= `LB_IDLE_N;
			r.wr <= `LB_IDLE_N;
			r.rdy <= `LB_IDLE_N;
		end
		else
			r <= next_r;
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign bus.bus_style_strap = r.strap;
	assign bus.slave_chip_select_n = r.cs_n;
	assign bus.host_addr = r.addr;
	assign bus.host_addr_oe_n = r.addr_oe_n;
	assign bus.host_data = r.data;
	assign bus.host_data_oe_n = r.data_oe_n;
	assign bus.host_rd = r.rd;
	assign bus.host_wr = r.wr;
	assign bus.host_strb_oe_n = r.strb_oe_n;
	assign bus.host_rdy = r.rdy;
	assign bus.host_rdy_oe_n = r.rdy_oe_n;
	assign cpu_done_o = r.cpu_done;
	assign cpu_rdata_o = r.cpu_rdata;
	assign periph_wr_o = r.periph_wr;
	assign periph_addr_o = r.periph_addr;
	assign periph_wdata_o = r.periph_wdata;
endmodule

// File: design/local_bus_if.sv
// Pin bundle joining the device end and the processor end
`timescale 1ns/10ps
`include "local_bus_map.svh"
interface local_bus_if
#(
	parameter int ADDR_W = `LB_ADDR_W,
	parameter int DATA_W = `LB_DATA_W
)
();
	logic bus_style_strap;
	logic local_ref_clock_out;
	logic slave_chip_select_n;
	logic [ADDR_W-1:0] dev_addr, host_addr, local_address_lines;
	logic dev_addr_oe_n, host_addr_oe_n;
	logic [DATA_W-1:0] dev_data, host_data, local_data_lines;
	logic dev_data_oe_n, host_data_oe_n;
	logic dev_rd, dev_wr, dev_strb_oe_n;
	logic host_rd, host_wr, host_strb_oe_n;
	logic dev_rdy, dev_rdy_oe_n, host_rdy, host_rdy_oe_n;
	logic read_strobe_n, write_strobe_n, cycle_ready;
	logic data_strobe_n, direction_line, transfer_ack_n;

	// Wire levels; an undriven line floats high as on a pulled-up board
	assign local_address_lines = (dev_addr_oe_n == `LB_OE_ON) ? dev_addr :
		(host_addr_oe_n == `LB_OE_ON) ? host_addr : '1;
	assign local_data_lines = (dev_data_oe_n == `LB_OE_ON) ? dev_data :
		(host_data_oe_n == `LB_OE_ON) ? host_data : '1;
	assign read_strobe_n = (dev_strb_oe_n == `LB_OE_ON) ? dev_rd :
		(host_strb_oe_n == `LB_OE_ON) ? host_rd : 1'b1;
	assign write_strobe_n = (dev_strb_oe_n == `LB_OE_ON) ? dev_wr :
		(host_strb_oe_n == `LB_OE_ON) ? host_wr : 1'b1;
	assign cycle_ready = (dev_rdy_oe_n == `LB_OE_ON) ? dev_rdy :
		(host_rdy_oe_n == `LB_OE_ON) ? host_rdy : 1'b1;

	// Same pins under their data-strobe style names
	assign data_strobe_n = read_strobe_n;
	assign direction_line = write_strobe_n;
	assign transfer_ack_n = cycle_ready;

	modport device_end (
		input bus_style_strap, slave_chip_select_n, local_address_lines,
		input local_data_lines, read_strobe_n, write_strobe_n, cycle_ready,
		input data_strobe_n, direction_line, transfer_ack_n,
		output local_ref_clock_out, dev_addr, dev_addr_oe_n, dev_data,
		output dev_data_oe_n, dev_rd, dev_wr, dev_strb_oe_n, dev_rdy,
		output dev_rdy_oe_n
	);
	modport host_end (
		input local_ref_clock_out, local_address_lines, local_data_lines,
		input read_strobe_n, write_strobe_n, cycle_ready,
		input data_strobe_n, direction_line, transfer_ack_n,
		output bus_style_strap, slave_chip_select_n, host_addr,
		output host_addr_oe_n, host_data, host_data_oe_n, host_rd, host_wr,
		output host_strb_oe_n, host_rdy, host_rdy_oe_n
	);
endinterface

// File: design/local_bus_map.svh
// Named constants shared by both ends of the local processor bus
`ifndef LOCAL_BUS_MAP_SVH
`define LOCAL_BUS_MAP_SVH
// ----------------------------------------
// Widths
// ----------------------------------------
`define LB_ADDR_W 13
`define LB_DATA_W 16
`define LB_DEC_W 8
// ----------------------------------------
// Levels and encodings
// ----------------------------------------
`define LB_STYLE_SEP 1'b0
`define LB_ACTIVE_N 1'b0
`define LB_IDLE_N 1'b1
`define LB_DIR_READ 1'b1
`define LB_RDY_SEP 1'b1
`define LB_RDY_DS 1'b0
`define LB_OE_ON 1'b0
`define LB_OE_OFF 1'b1
// ----------------------------------------
// Timing
// ----------------------------------------
// Clock cycles per half period of the reference clock output
`define LB_REF_HALF 1
`endif

// File: design/local_bus_pkg.sv
// State types for both ends of the local processor bus
package local_bus_pkg;
	typedef enum logic [1:0] {
		SL_IDLE = 2'h0,
		SL_READY = 2'h1,
		SL_HOLD = 2'h2
	} slave_state_type;
	typedef enum logic [1:0] {
		M_IDLE = 2'h0,
		M_SETUP = 2'h1,
		M_STROBE = 2'h2
	} master_state_type;
	typedef enum logic [2:0] {
		H_IDLE = 3'h0,
		H_SETUP = 3'h1,
		H_STROBE = 3'h2,
		P_ACK = 3'h3,
		P_WAIT = 3'h4
	} host_state_type;
endpackage

// File: test/local_bus_asserts.sv
// Checker watching the wires between the device end and the processor end
`timescale 1ns/10ps
module local_bus_asserts
(
	input wire logic clock_i,
	input wire logic sys_rst_i,
	input wire logic bus_style_strap,
	input wire logic local_ref_clock_out,
	input wire logic slave_chip_select_n,
	input wire logic dev_addr_oe_n,
	input wire logic dev_data_oe_n,
	input wire logic host_data_oe_n,
	input wire logic dev_strb_oe_n,
	input wire logic read_strobe_n,
	input wire logic write_strobe_n,
	input wire logic cycle_ready,
	input wire logic data_strobe_n,
	input wire logic direction_line,
	input wire logic transfer_ack_n
);
	// One clock domain, so clock and reset are given once
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (sys_rst_i);
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	property p_ref_fall;
		local_ref_clock_out |=> !local_ref_clock_out;
	endproperty
	property p_ref_rise;
		$fell(local_ref_clock_out) |=> local_ref_clock_out;
	endproperty
	// Two drivers at once would short the data lines
	property p_one_driver;
		!(dev_data_oe_n == 1'b0 && host_data_oe_n == 1'b0);
	endproperty
	property p_data_cause;
		$fell(dev_data_oe_n) |-> dev_strb_oe_n == 1'b0 ||
			(!slave_chip_select_n && (bus_style_strap ?
			(direction_line && !data_strobe_n) : !read_strobe_n));
	endproperty
	property p_addr_master;
		dev_addr_oe_n == dev_strb_oe_n;
	endproperty
	// Data must already stand a cycle before ready rises
	property p_sep_read;
		$rose(cycle_ready) && !bus_style_strap && !slave_chip_select_n &&
			!read_strobe_n |-> !dev_data_oe_n && !$past(dev_data_oe_n);
	endproperty
	// Ready only after the synchroniser has seen the strobe
	property p_sep_write;
		$rose(cycle_ready) && !bus_style_strap && !slave_chip_select_n &&
			!write_strobe_n |-> $past(write_strobe_n, 3) == 1'b0;
	endproperty
	property p_ds_read;
		$fell(transfer_ack_n) && bus_style_strap && !slave_chip_select_n &&
			direction_line |-> dev_data_oe_n == 1'b0;
	endproperty
	property p_ds_write;
		$fell(transfer_ack_n) && bus_style_strap && !slave_chip_select_n &&
			!direction_line |-> $past(data_strobe_n, 3) == 1'b0;
	endproperty
	// Master strobe ends only right after a fresh ready edge
	property p_master_wait;
		$rose(read_strobe_n) && !dev_strb_oe_n |->
			$past(cycle_ready) != $past(cycle_ready, 2);
	endproperty
	// ----------------------------------------
	// Assertions and covers
	// ----------------------------------------
	a_ref_fall: assert property (p_ref_fall)
		else $error("reference clock stuck high");
	a_ref_rise: assert property (p_ref_rise)
		else $error("reference clock stuck low");
	a_one_driver: assert property (p_one_driver)
		else $error("data lines driven from both ends");
	a_data_cause: assert property (p_data_cause)
		else $error("device drove data outside a read");
	a_addr_master: assert property (p_addr_master)
		else $error("address drive differs from master drive");
	a_sep_read: assert property (p_sep_read)
		else $error("ready before read data");
	a_sep_write: assert property (p_sep_write)
		else $error("ready too early on write");
	a_ds_read: assert property (p_ds_read)
		else $error("acknowledge without read data");
	a_ds_write: assert property (p_ds_write)
		else $error("acknowledge too early on write");
	a_master_wait: assert property (p_master_wait)
		else $error("master ended without ready");
	c_sep_read: cover property (p_sep_read);
	c_ds_read: cover property (p_ds_read);
	c_master: cover property ($rose(read_strobe_n) && !dev_strb_oe_n);
endmodule

// File: test/testbench.sv
// Self-checking bench joining the device end to the processor end
`timescale 1ns/10ps
module testbench;
	logic clock_i, sys_rst_i, strap_i, master_enable_i, periph_mode_i;
	logic mst_req_i, mst_write_i, cpu_req_i, cpu_write_i;
	logic [12:0] mst_addr_i, cpu_addr_i, periph_addr_o;
	logic [15:0] mst_wdata_i, cpu_wdata_i, periph_rdata_i, wire_data;
	logic mst_done_o, slv_wr_o, cpu_done_o, periph_wr_o;
	logic [15:0] mst_rdata_o, slv_data_o, cpu_rdata_o, periph_wdata_o;
	logic [7:0] slv_addr_o;
	int err_total, checks_done, slv_count, periph_count;
	int model [256];
	// ----------------------------------------
	// Design and checker
	// ----------------------------------------
	local_bus_if local_bus_if_inst ();
	local_bus_device local_bus_device_inst (.clock_i(clock_i),
		.sys_rst_i(sys_rst_i), .bus(local_bus_if_inst),
		.master_enable_i(master_enable_i), .mst_req_i(mst_req_i),
		.mst_write_i(mst_write_i), .mst_addr_i(mst_addr_i),
		.mst_wdata_i(mst_wdata_i), .mst_done_o(mst_done_o),
		.mst_rdata_o(mst_rdata_o), .slv_wr_o(slv_wr_o),
		.slv_addr_o(slv_addr_o), .slv_data_o(slv_data_o));
	local_bus_host local_bus_host_inst (.clock_i(clock_i),
		.sys_rst_i(sys_rst_i), .bus(local_bus_if_inst), .strap_i(strap_i),
		.periph_mode_i(periph_mode_i), .cpu_req_i(cpu_req_i),
		.cpu_write_i(cpu_write_i), .cpu_addr_i(cpu_addr_i),
		.cpu_wdata_i(cpu_wdata_i), .cpu_done_o(cpu_done_o),
		.cpu_rdata_o(cpu_rdata_o), .periph_rdata_i(periph_rdata_i),
		.periph_wr_o(periph_wr_o), .periph_addr_o(periph_addr_o),
		.periph_wdata_o(periph_wdata_o));
	local_bus_asserts local_bus_asserts_inst (.clock_i(clock_i),
		.sys_rst_i(sys_rst_i),
		.bus_style_strap(local_bus_if_inst.bus_style_strap),
		.local_ref_clock_out(local_bus_if_inst.local_ref_clock_out),
		.slave_chip_select_n(local_bus_if_inst.slave_chip_select_n),
		.dev_addr_oe_n(local_bus_if_inst.dev_addr_oe_n),
		.dev_data_oe_n(local_bus_if_inst.dev_data_oe_n),
		.host_data_oe_n(local_bus_if_inst.host_data_oe_n),
		.dev_strb_oe_n(local_bus_if_inst.dev_strb_oe_n),
		.read_strobe_n(local_bus_if_inst.read_strobe_n),
		.write_strobe_n(local_bus_if_inst.write_strobe_n),
		.cycle_ready(local_bus_if_inst.cycle_ready),
		.data_strobe_n(local_bus_if_inst.data_strobe_n),
		.direction_line(local_bus_if_inst.direction_line),
		.transfer_ack_n(local_bus_if_inst.transfer_ack_n));
	// ----------------------------------------
	// Clock and monitors
	// ----------------------------------------
	always #12.5 clock_i = ~clock_i;
	// Counts pulses and keeps the data seen on the last acknowledged cycle
	always @(negedge clock_i)
	begin
		if (slv_wr_o === 1'b1)
			slv_count++;
		if (periph_wr_o === 1'b1)
			periph_count++;
		if (local_bus_if_inst.slave_chip_select_n === 1'b0 &&
			local_bus_if_inst.cycle_ready === !strap_i)
			wire_data = local_bus_if_inst.local_data_lines;
	end
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic conclude();
		if (err_total == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			err_total++;
			$display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// Bounded wait for a done pulse; the master has no timeout of its own
	task automatic wait_done(input logic master);
		for (int k = 0; k < 40; k++)
		begin
			@(negedge clock_i);
			if ((master ? mst_done_o : cpu_done_o) === 1'b1)
				return;
		end
		err_total++;
		conclude();
	endtask
	// Request pulsed for one cycle so a level is not taken twice
	task automatic cpu_op(input logic wr, input logic [12:0] a,
		input logic [15:0] d);
		int n;
		n = slv_count;
		wire_data = 'x;
		@(posedge clock_i);
		cpu_req_i <= 1'b1;
		cpu_write_i <= wr;
		cpu_addr_i <= a;
		cpu_wdata_i <= d;
		@(posedge clock_i);
		cpu_req_i <= 1'b0;
		wait_done(1'b0);
		if (wr)
		begin
			model[a[7:0]] = d;
			chk(slv_count, n + 1);
			chk(slv_addr_o, a[7:0]);
			chk(slv_data_o, d);
		end
		else
		begin
			chk(cpu_rdata_o, model[a[7:0]]);
			chk(wire_data, model[a[7:0]]);
		end
	endtask
	task automatic mst_op(input logic wr, input logic [12:0] a,
		input logic [15:0] d);
		int n;
		n = periph_count;
		@(posedge clock_i);
		mst_req_i <= 1'b1;
		mst_write_i <= wr;
		mst_addr_i <= a;
		mst_wdata_i <= d;
		periph_rdata_i <= ~d;
		@(posedge clock_i);
		mst_req_i <= 1'b0;
		wait_done(1'b1);
		chk(local_bus_if_inst.local_address_lines, a);
		// Peripheral address is only latched on writes
		if (wr)
		begin
			chk(periph_count, n + 1);
			chk(periph_addr_o, a);
			chk(periph_wdata_o, d);
		end
		else
			chk(mst_rdata_o, 16'(~d));
	endtask
	// ----------------------------------------
	// Main sequence, once for each bus style
	// ----------------------------------------
	initial
	begin
		logic [12:0] a;
		logic [15:0] d;
		{clock_i, strap_i, master_enable_i, periph_mode_i} = 4'h0;
		{mst_req_i, mst_write_i, cpu_req_i, cpu_write_i} = 4'h0;
		{mst_addr_i, cpu_addr_i} = 26'h000_0000;
		{mst_wdata_i, cpu_wdata_i, periph_rdata_i} = 48'h0000_0000_0000;
		sys_rst_i = 1'b1;
		void'($urandom(7627));
		for (int s = 0; s < 2; s++)
		begin
			@(posedge clock_i);
			sys_rst_i <= 1'b1;
			strap_i <= s[0];
			repeat (12) @(posedge clock_i);
			sys_rst_i <= 1'b0;
			foreach (model[j])
				model[j] = 0;
			repeat (2) @(posedge clock_i);
			chk(local_bus_if_inst.bus_style_strap, s[0]);
			for (int i = 0; i < 12; i++)
			begin
				a = 13'($urandom);
				d = 16'($urandom);
				cpu_op(1'b0, a, d);
				cpu_op(1'b1, a, d);
				cpu_op(1'b0, a ^ 13'h1f00, d);
				cpu_op(1'b0, 13'($urandom), d);
			end
			@(posedge clock_i);
			master_enable_i <= 1'b1;
			periph_mode_i <= 1'b1;
			repeat (3) @(posedge clock_i);
			for (int i = 0; i < 8; i++)
				mst_op(i[0], 13'($urandom), 16'($urandom));
			@(posedge clock_i);
			master_enable_i <= 1'b0;
			periph_mode_i <= 1'b0;
			repeat (8) @(negedge clock_i);
			chk(local_bus_if_inst.local_data_lines, 16'hffff);
			chk(local_bus_if_inst.dev_addr_oe_n, 1'b1);
			cpu_op(1'b0, a, d);
		end
		conclude();
	end
endmodule
